// *** logic/cfg_port_params.svh ***
// Constants for the two-wire serial configuration write port.
`ifndef CFG_PORT_PARAMS_SVH
`define CFG_PORT_PARAMS_SVH
`define CFG_ADDR_BITS 7
`define CFG_BYTE_BITS 8
`define CFG_BIT_MSB 3'h7
`define CFG_PTR_STEP 8'h01
`define CFG_PTR_RESET 8'h00
`define CFG_DEV_ADDR_DEFAULT 7'h55
`define CFG_MAX_RATE_KBPS 400
`endif

// *** logic/cfg_port_pkg.sv ***
// Types shared by the serial configuration write port.
package cfg_port_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_ptr,
    st_ptr_ack,
    st_data,
    st_data_ack,
    st_ignore
  } phase_e;
endpackage

// *** logic/pin_sync.sv ***
// Two flip-flop synchroniser for the serial clock and data pins.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;

  // Idle bus lines are high, so both stages start high to avoid a false start.
  always_comb
  begin
    nxt_st = st_ff;
    if (ce)
    begin
      nxt_st.stage1 = async_in;
      nxt_st.stage2 = st_ff.stage1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st_ff <= '{stage1: '1, stage2: '1};
    else
      st_ff <= nxt_st;
  end

  assign sync_out = st_ff.stage2;
endmodule

// *** logic/serial_config_write_port.sv ***
// Two-wire serial configuration slave that writes bytes to a register file.
`timescale 1ns/1ps
`include "cfg_port_params.svh"
// Function
// R1: Master must enable serial-port operation in stored configuration before transfers.
// R2: Port works read and write up to 400 kbit/s. This port only writes; reads are flagged on read_request and return no data.
// R3: Write order: start, address, direction, ack, pointer, ack, data, ack.
// R4: Each further data byte goes to previous pointer plus one until stop.
// R5: Data line changes only while clock is low, stable while high.
// R6: Data falling while clock high is a start condition.
// R7: After start the master sends address byte, pointer byte, then data.
// R8: Data rising while clock high is a stop condition.
// R9: Stop releases the bus; new pointer needs new start and address.
// R10: Device acknowledges each written byte by pulling data low on ninth clock.
// R11: In read direction the master drives the acknowledge, not the device.
// R12: Bytes are shifted most significant bit first.
module serial_config_write_port #(
  parameter logic [6:0] DEV_ADDR = `CFG_DEV_ADDR_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic port_enable,
  input wire logic serial_clock_in,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic frame_active,
  output logic read_request
);
  // Value 0x55 for DEV_ADDR is arbitrary.
  typedef struct packed {
    cfg_port_pkg::phase_e phase;
    logic scl_prev;
    logic sda_prev;
    logic [2:0] bit_cnt;
    logic byte_full;
    logic [7:0] shift;
    logic [7:0] register_pointer;
    logic ack_drive;
    logic strobe;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [1:0] pins_sync;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // Both pins come from the master's domain, so they are synchronised first.
  // The system clock oversamples the link far above its top bit rate. [R2]
  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .async_in({serial_clock_in, serial_data_line_in}),
    .sync_out(pins_sync)
  );

  assign scl = pins_sync[1];
  assign sda = pins_sync[0];
  assign scl_rise = scl & ~st_ff.scl_prev;
  assign scl_fall = ~scl & st_ff.scl_prev;
  // Data edges with the clock held high frame the transfer.
  assign start_cond = scl & st_ff.scl_prev & st_ff.sda_prev & ~sda; // [R6]
  assign stop_cond = scl & st_ff.scl_prev & ~st_ff.sda_prev & sda; // [R8]

  // True when the upper seven bits of a byte name this device.
  function automatic logic addr_match(input logic [7:0] b);
    addr_match = (b[7:1] == DEV_ADDR);
  endfunction

  // True when a byte names this device with the write direction bit.
  function automatic logic is_write(input logic [7:0] b);
    is_write = addr_match(b) && !b[0];
  endfunction

  // True in the phases that collect eight bits from the line.
  function automatic logic byte_phase(input cfg_port_pkg::phase_e p);
    byte_phase = (p == cfg_port_pkg::st_addr) ||
                 (p == cfg_port_pkg::st_ptr) ||
                 (p == cfg_port_pkg::st_data);
  endfunction

  // Byte handling: bits sampled on clock rise, ack driven from clock fall.
  // The ack is taken and dropped on falling clock edges, so the line
  // only moves while the clock is low and no false start or stop appears.
  always_comb
  begin
    nxt_st = st_ff;
    if (ce)
    begin
      nxt_st.strobe = 1'b0;
      nxt_st.scl_prev = scl;
      nxt_st.sda_prev = sda;
      if (!port_enable)
      begin
        // A disabled port stays deaf to the bus. [R1]
        nxt_st.phase = cfg_port_pkg::st_idle;
        nxt_st.ack_drive = 1'b0;
        nxt_st.byte_full = 1'b0;
        nxt_st.rd = 1'b0;
      end
      else if (stop_cond)
      begin
        nxt_st.phase = cfg_port_pkg::st_idle; // [R9]
        nxt_st.ack_drive = 1'b0;
        nxt_st.byte_full = 1'b0;
        nxt_st.rd = 1'b0;
      end
      else if (start_cond)
      begin
        // Repeated start also lands here and restarts the address phase.
        nxt_st.phase = cfg_port_pkg::st_addr; // [R3] [R9]
        nxt_st.bit_cnt = 3'h0;
        nxt_st.byte_full = 1'b0;
        nxt_st.ack_drive = 1'b0;
        nxt_st.rd = 1'b0;
      end
      else
      begin
        // Shift in one bit per rising clock while a byte is still open.
        if (byte_phase(st_ff.phase) && scl_rise && !st_ff.byte_full)
        begin
          // Sampled on the rising edge, when the line is stable. [R5]
          nxt_st.shift = {st_ff.shift[6:0], sda}; // [R12]
          nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
          nxt_st.byte_full = (st_ff.bit_cnt == `CFG_BIT_MSB);
        end
        case (st_ff.phase)
          cfg_port_pkg::st_addr:
          begin
            if (scl_fall && st_ff.byte_full)
            begin
              nxt_st.byte_full = 1'b0;
              if (is_write(st_ff.shift))
              begin
                nxt_st.phase = cfg_port_pkg::st_addr_ack; // [R3]
                nxt_st.ack_drive = 1'b1; // [R10]
              end
              else
              begin
                // Reads are only flagged; this port returns no data, and
                // another device's frame is ignored until its stop.
                nxt_st.rd = addr_match(st_ff.shift);
                nxt_st.phase = cfg_port_pkg::st_ignore;
              end
            end
          end
          cfg_port_pkg::st_ptr:
          begin
            if (scl_fall && st_ff.byte_full)
            begin
              nxt_st.byte_full = 1'b0;
              nxt_st.register_pointer = st_ff.shift; // [R3]
              nxt_st.phase = cfg_port_pkg::st_ptr_ack;
              nxt_st.ack_drive = 1'b1; // [R10]
            end
          end
          cfg_port_pkg::st_data:
          begin
            if (scl_fall && st_ff.byte_full)
            begin
              nxt_st.byte_full = 1'b0;
              nxt_st.strobe = 1'b1;
              nxt_st.wr_addr = st_ff.register_pointer;
              nxt_st.wr_data = st_ff.shift;
              // The pointer wraps at the top of the byte range.
              nxt_st.register_pointer = st_ff.register_pointer +
                                        `CFG_PTR_STEP; // [R4]
              nxt_st.phase = cfg_port_pkg::st_data_ack;
              nxt_st.ack_drive = 1'b1; // [R10]
            end
          end
          cfg_port_pkg::st_addr_ack:
          begin
            // The fall that ends the ninth clock releases the line.
            if (scl_fall)
            begin
              nxt_st.ack_drive = 1'b0;
              nxt_st.phase = cfg_port_pkg::st_ptr;
            end
          end
          cfg_port_pkg::st_ptr_ack:
          begin
            if (scl_fall)
            begin
              nxt_st.ack_drive = 1'b0;
              nxt_st.phase = cfg_port_pkg::st_data;
            end
          end
          cfg_port_pkg::st_data_ack:
          begin
            // Further bytes keep landing until a stop arrives. [R4]
            if (scl_fall)
            begin
              nxt_st.ack_drive = 1'b0;
              nxt_st.phase = cfg_port_pkg::st_data;
            end
          end
          default:
          begin
            // Idle and ignore wait for a start or a stop.
            nxt_st.ack_drive = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.scl_prev <= 1'b1;
      st_ff.sda_prev <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_n = ~st_ff.ack_drive;
  assign wr_strobe = st_ff.strobe;
  assign wr_addr = st_ff.wr_addr;
  assign wr_data = st_ff.wr_data;
  assign frame_active = (st_ff.phase != cfg_port_pkg::st_idle);
  assign read_request = st_ff.rd;
endmodule

// *** tb/two_wire_master.sv ***
// Bus master model that drives the serial clock and data line.
`timescale 1ns/1ps
module two_wire_master (
  input wire logic clk_sys,
  input wire logic line,
  output logic scl,
  output logic sda
);
  initial {scl, sda} = 2'h3;
  // A 40 ns step, three per bit, gives the link clock a 120 ns period.
  task automatic hp();
    repeat (4) @(posedge clk_sys);
  endtask
  // Start: sda falls while scl is high.
  task automatic start();
    sda <= 1'h0;
    hp();
    scl <= 1'h0;
  endtask
  // Stop: sda rises while scl is high, then the bus idles high.
  task automatic stop();
    hp();
    sda <= 1'h0;
    hp();
    scl <= 1'h1;
    hp();
    sda <= 1'h1;
    hp();
  endtask
  // Msb first, sda moved only with scl low, ninth clock released.
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      hp();
      sda <= (i > 0) ? b[i-1] : 1'h1;
      hp();
      scl <= 1'h1;
      hp();
      ack = !line;
      scl <= 1'h0;
    end
  endtask
endmodule

// *** tb/cfg_port_chk.sv ***
// Assertions on the pins and write strobes of the configuration port.
`timescale 1ns/1ps
module cfg_port_chk (
  input wire logic clk_sys, rst, ce, port_enable, serial_clock_in,
  input wire logic serial_data_line_in, serial_data_line_out,
  input wire logic serial_data_line_oe_n, wr_strobe, frame_active,
  input wire logic read_request,
  input wire logic [7:0] wr_addr, wr_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // The line is open drain, so the port may only pull it low.
  a_drive_low: assert property (!serial_data_line_oe_n |->
    !serial_data_line_out) else $error("line driven high");
  a_idle_free: assert property (!frame_active |->
    serial_data_line_oe_n) else $error("line held outside frame");
  a_off_quiet: assert property (!port_enable |->
    serial_data_line_oe_n && !wr_strobe) else $error("active while off");
  a_grab_low: assert property ($fell(serial_data_line_oe_n) |->
    !serial_clock_in) else $error("drive with clock high");
  a_free_low: assert property ($rose(serial_data_line_oe_n) |->
    !serial_clock_in) else $error("release with clock high");
  a_strobe_in: assert property (wr_strobe |-> frame_active)
    else $error("write outside frame");
  a_strobe_once: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe too long");
  a_start_seen: assert property ($rose(frame_active) |->
    serial_clock_in && !serial_data_line_in) else $error("bad start");
  a_stop_seen: assert property ($fell(frame_active) |->
    serial_clock_in && serial_data_line_in) else $error("bad stop");
  c_write: cover property (wr_strobe);
  c_ack: cover property ($fell(serial_data_line_oe_n));
  c_stop: cover property ($fell(frame_active));
endmodule
bind serial_config_write_port cfg_port_chk i_chk (.*);

// *** tb/testbench.sv ***
// Self-checking bench for the serial configuration write port.
`timescale 1ns/1ps
`include "cfg_port_params.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
  logic clk_sys = 0, rst = 1, port_enable = 0, ack, scl, sda, line, out;
  logic oe_n, stb, act, rdq;
  logic [7:0] addr, data, qa[$], qd[$];
  logic [7:0] dev = {`CFG_DEV_ADDR_DEFAULT, 1'h0};
  int num_errors = 0, cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  // Wired-and bus with a pull-up; either side may pull it low.
  assign line = sda & (oe_n | out);
  two_wire_master i_m (.clk_sys(clk_sys), .line(line), .scl(scl),
    .sda(sda));
  serial_config_write_port i_dut (.clk_sys(clk_sys), .rst(rst),
    .ce(1'h1), .port_enable(port_enable), .serial_clock_in(scl),
    .serial_data_line_in(line), .serial_data_line_out(out),
    .serial_data_line_oe_n(oe_n), .wr_strobe(stb), .wr_addr(addr),
    .wr_data(data), .frame_active(act), .read_request(rdq));
  // Log every register write the port makes.
  always @(posedge clk_sys)
    if (stb === 1'h1)
    begin
      qa.push_back(addr);
      qd.push_back(data);
    end
  // One whole frame of four bytes; e is the expected acknowledge.
  task automatic frame(input logic [7:0] d, p, a, b, input logic e);
    logic [7:0] f [4] = '{d, p, a, b};
    qa.delete();
    qd.delete();
    i_m.start();
    for (int i = 0; i < 4; i++)
    begin
      i_m.send(f[i], ack);
      `CHK("ack", e, ack)
    end
    i_m.stop();
  endtask
  task automatic t_burst();
    frame(dev, 8'hfe, 8'h3c, 8'hc3, 1'h1);
    `CHK("n", 2, qa.size())
    `CHK("a1", 8'hff, qa[1])
    `CHK("d0", 8'h3c, qd[0])
    `CHK("d1", 8'hc3, qd[1])
    $display("burst done");
  endtask
  // A new start moves the pointer anywhere.
  task automatic t_restart();
    frame(dev, 8'h7f, 8'h01, 8'h02, 1'h1);
    `CHK("a0", 8'h7f, qa[0])
    `CHK("a1", 8'h80, qa[1])
    $display("restart done");
  endtask
  task automatic t_foreign();
    frame({7'h2a, 1'h0}, 8'h10, 8'h11, 8'h12, 1'h0);
    `CHK("n", 0, qa.size())
    $display("foreign done");
  endtask
  // A read frame is flagged, writes nothing and ends idle after the stop.
  task automatic t_read();
    qa.delete();
    i_m.start();
    `CHK("act", 1'h1, act)
    i_m.send({dev[7:1], 1'h1}, ack);
    `CHK("rd", 1'h1, rdq)
    i_m.stop();
    `CHK("idle", 1'h0, act)
    `CHK("n", 0, qa.size())
    $display("read done");
  endtask
  task automatic t_off();
    port_enable <= 1'h0;
    frame(dev, 8'h20, 8'h21, 8'h22, 1'h0);
    `CHK("n", 0, qa.size())
    port_enable <= 1'h1;
    $display("off done");
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    port_enable <= 1'h1;
    t_burst();
    t_restart();
    t_foreign();
    t_read();
    t_off();
    results();
  end
endmodule
